// ### spcs_serial_port.sv
// serial port control and status with transmitter and receiver
// assumes pins arrive unsynchronised; register port is on clk
//
// The plain strobed port is this design's own decision.
`timescale 1ns/10ps

// Summary of operation
// R1: parity generated and checked only when enabled and in 7 or 8 bit frames
// R2: parity select 00 odd, 01 even, 10 mark, 11 space
// R3: in 9 bit frames the low parity select bit is the sent ninth bit
// R4: frame length 00 eight, 01 seven, 10 nine data bits; reset clears
// R5: frame length 11 loops transmitter into receiver using nine bit frames
// R6: read-only global error flag is the or of overrun, framing, parity
// R7: receive-full sets when a character completes, clears when buffer is read and none completes
// R8: transmit-empty sets on move to shifter, clears on buffer write, resets one
// R9: software writes zero to the reserved receive status bit; it stays read/write
// R10: error flags stick until the receive status register is read
// R11: ninth received bit kept in a read-only status bit
// R12: attention bit cleared by hardware when a character with ninth bit one arrives
// R13: transmitting indicator high until end of last stop bit of final frame
// R14: receive-line indicator set on framing error, cleared when line is high
// R15: stop-count bit gives one or two stop bits
// R16: short-stop bit makes the last stop bit seven eighths long in asynchronous mode
// R17: transmit-pin enable connects serial output to pin L2
// R18: software makes a line break by disabling the pin and driving port low
// R19: mode bit selects asynchronous when zero, synchronous when one
// R20: receiver clock from internal divider, or external clock pin when set
// R21: transmitter clock from internal divider, or external clock pin when set
// R22: receive interrupt enable bit gates receiver interrupts
// R23: lowest interrupt/clock register bit enables transmitter interrupts
// R24: asynchronous clock is sixteen times baud, synchronous equals baud
// R25: transmit interrupt pending while transmit-empty and its enable
// R26: receive interrupt pending while receive-full and its enable
// R27: overrun set when a character completes while receive-full is set
module spcs_serial_port (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst_n,
	// register port
	input  wire logic [7:0] addr,
	input  wire logic [7:0] wdata,
	input  wire logic       wr_en,
	input  wire logic       rd_en,
	output logic      [7:0] rdata,
	// serial pins
	input  wire logic       serial_rx_pin,
	input  wire logic       serial_ext_clock_pin,
	output logic            serial_tx_pin,
	output logic            tx_pin_enable,
	output logic            tx_pin_oe_n,
	// interrupt requests
	output logic            tx_irq_pending,
	output logic            rx_irq_pending
);

	// ****************************************
	// registers
	// ****************************************
	logic [7:0]           ctrl_cfg;
	logic [7:0]           rxst_cfg;
	logic [7:0]           ics;
	logic [7:0]           divisor;
	logic [7:0]           div_cnt;
	logic [7:0]           transmit_buffer;
	logic [7:0]           receive_buffer;
	logic                 tx_empty_flag;
	logic                 rx_full_flag;
	logic                 overrun_error;
	logic                 framing_error;
	logic                 parity_error;
	logic                 rx_ninth_bit;
	logic                 rx_line_indicator;
	logic [1:0]           sync1;
	logic [1:0]           sync2;
	logic [1:0]           sync3;
	logic [1:0]           pin_lvl;
	spcs_pkg::spcs_tx_t   tx_state;
	spcs_pkg::spcs_tx_t   next_tx_state;
	spcs_pkg::spcs_rx_t   rx_state;
	spcs_pkg::spcs_rx_t   next_rx_state;
	logic [8:0]           transmit_shifter;
	logic [8:0]           receive_shifter;
	logic [3:0]           tx_sub;
	logic [3:0]           tx_idx;
	logic [3:0]           rx_sub;
	logic [3:0]           rx_idx;
	logic                 rx_par_bad;

	// parity over seven or eight data bits
	function automatic logic spcs_parity(input logic [7:0] d, input logic seven, input logic [1:0] sel);
		logic x;
		x = ^(seven ? {1'b0, d[6:0]} : d);
		unique case (sel)
			spcs_pkg::PAR_ODD:   spcs_parity = ~x;
			spcs_pkg::PAR_EVEN:  spcs_parity = x;
			spcs_pkg::PAR_MARK:  spcs_parity = 1'b1;
			spcs_pkg::PAR_SPACE: spcs_parity = 1'b0;
		endcase
	endfunction : spcs_parity

	// ****************************************
	// decode
	// ****************************************
	wire       wr_txbuf  = wr_en && addr == spcs_pkg::ADDR_TX_BUF;
	wire       rd_rxbuf  = rd_en && addr == spcs_pkg::ADDR_RX_BUF;
	wire       rd_rxst   = rd_en && addr == spcs_pkg::ADDR_RXST;
	wire [1:0] frame_len = {ctrl_cfg[spcs_pkg::C_FRAME_LEN_HI], ctrl_cfg[spcs_pkg::C_FRAME_LEN_LO]}; // see R4
	wire       nine      = frame_len[1];                                              // see R5
	wire       seven     = frame_len == spcs_pkg::FLEN_7;
	wire       loopback  = frame_len == spcs_pkg::FLEN_LOOP;                          // see R5
	wire       par_on    = ctrl_cfg[spcs_pkg::C_PEN] && !nine;                        // see R1
	wire [1:0] par_sel   = {ctrl_cfg[spcs_pkg::C_PARITY_SELECT_HI], ctrl_cfg[spcs_pkg::C_PARITY_SELECT_LO]};
	wire       tx_ninth_bit = ctrl_cfg[spcs_pkg::C_PARITY_SELECT_LO];                            // see R3
	wire       sync_mode = ics[spcs_pkg::I_SSEL];                                     // see R19
	wire       two_stop  = ics[spcs_pkg::I_TWO_STOP_SELECT];
	wire       short_stop = ics[spcs_pkg::I_SHORT_STOP_SELECT] && !sync_mode;
	wire       attention_enable = rxst_cfg[spcs_pkg::S_ATTENTION_ENABLE];
	wire [3:0] last_idx  = nine ? spcs_pkg::IDX_9 : (seven ? spcs_pkg::IDX_7 : spcs_pkg::IDX_8);
	wire       err_any   = overrun_error || framing_error || parity_error;             // see R6
	wire       tx_active = tx_state != spcs_pkg::SPCS_TX_IDLE;                        // see R13

	// ****************************************
	// pin synchronisers and clock ticks
	// ****************************************
	// a level is taken only once stages two and three agree
	wire [1:0] agree    = ~(sync2 ^ sync3);
	wire       ext_rise = agree[1] && sync3[1] && !pin_lvl[1];
	wire       ext_fall = agree[1] && !sync3[1] && pin_lvl[1];
	wire       int_tick = div_cnt == divisor;
	wire       tx_tick  = ics[spcs_pkg::I_TX_EXT_CLOCK_SELECT] ? ext_rise : int_tick;            // see R21
	wire       rx_ext_tick = sync_mode ? ext_fall : ext_rise;
	wire       rx_tick  = ics[spcs_pkg::I_RX_EXT_CLOCK_SELECT] ? rx_ext_tick : int_tick;         // see R20
	wire       rx_line  = loopback ? serial_tx_pin : pin_lvl[0];                   // see R5

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sync1   <= 2'h3;
			sync2   <= 2'h3;
			sync3   <= 2'h3;
			pin_lvl <= 2'h3;
			div_cnt <= spcs_pkg::REG_RESET;
		end else begin
			sync1   <= {serial_ext_clock_pin, serial_rx_pin};
			sync2   <= sync1;
			sync3   <= sync2;
			pin_lvl <= (agree & sync3) | (~agree & pin_lvl);
			div_cnt <= int_tick ? spcs_pkg::REG_RESET : 8'(div_cnt + spcs_pkg::CNT_ONE);
		end
	end

	// ****************************************
	// transmitter
	// ****************************************
	// async bits span sixteen ticks, a short last stop fourteen, sync bits one tick
	wire tx_last_stop = tx_state == spcs_pkg::SPCS_TX_STOP2 || (tx_state == spcs_pkg::SPCS_TX_STOP1 && !two_stop);
	wire [3:0] tx_limit = (short_stop && tx_last_stop) ? spcs_pkg::OVS_SHORT : spcs_pkg::OVS_LAST; // see R16
	wire tx_bit_end = tx_tick && (sync_mode || tx_sub == tx_limit);                 // see R24
	wire tx_done    = tx_bit_end && tx_last_stop;
	// a buffer write blocks the move so the new byte is never lost
	wire tx_load    = !tx_empty_flag && !wr_txbuf && (!tx_active || tx_done);
	wire tx_par_val = spcs_parity(transmit_shifter[7:0], seven, par_sel);           // see R2
	// the edge that ends a data bit must already put out the following bit
	wire [3:0] tx_bit_idx = (tx_state != spcs_pkg::SPCS_TX_DATA) ? spcs_pkg::IDX_ZERO
		: (tx_bit_end ? 4'(tx_idx + spcs_pkg::IDX_ONE) : tx_idx);
	logic next_tx_line;

	always_comb begin
		next_tx_state = tx_state;
		if (tx_load) begin
			next_tx_state = spcs_pkg::SPCS_TX_START;
		end else if (tx_bit_end) begin
			unique case (tx_state)
				spcs_pkg::SPCS_TX_IDLE:  next_tx_state = spcs_pkg::SPCS_TX_IDLE;
				spcs_pkg::SPCS_TX_START: next_tx_state = spcs_pkg::SPCS_TX_DATA;
				spcs_pkg::SPCS_TX_DATA: begin
					if (tx_idx == last_idx)
						next_tx_state = par_on ? spcs_pkg::SPCS_TX_PAR : spcs_pkg::SPCS_TX_STOP1; // see R1
				end
				spcs_pkg::SPCS_TX_PAR:   next_tx_state = spcs_pkg::SPCS_TX_STOP1;
				spcs_pkg::SPCS_TX_STOP1: next_tx_state = two_stop ? spcs_pkg::SPCS_TX_STOP2 : spcs_pkg::SPCS_TX_IDLE; // see R15
				spcs_pkg::SPCS_TX_STOP2: next_tx_state = spcs_pkg::SPCS_TX_IDLE;
				default:                 next_tx_state = spcs_pkg::SPCS_TX_IDLE;
			endcase
		end
	end

	always_comb begin
		unique case (next_tx_state)
			spcs_pkg::SPCS_TX_START: next_tx_line = 1'b0;
			spcs_pkg::SPCS_TX_DATA:  next_tx_line = transmit_shifter[tx_bit_idx];
			spcs_pkg::SPCS_TX_PAR:   next_tx_line = tx_par_val;
			default:                 next_tx_line = 1'b1;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			tx_state         <= spcs_pkg::SPCS_TX_IDLE;
			transmit_shifter <= 9'h1FF;
			tx_sub           <= spcs_pkg::IDX_ZERO;
			tx_idx           <= spcs_pkg::IDX_ZERO;
			serial_tx_pin    <= 1'b1;
		end else begin
			tx_state      <= next_tx_state;
			serial_tx_pin <= next_tx_line;
			if (tx_load)
				transmit_shifter <= {tx_ninth_bit, transmit_buffer};                    // see R3
			if (tx_load || tx_bit_end)
				tx_sub <= spcs_pkg::IDX_ZERO;
			else if (tx_tick)
				tx_sub <= 4'(tx_sub + spcs_pkg::IDX_ONE);
			if (tx_bit_end)
				tx_idx <= (tx_state == spcs_pkg::SPCS_TX_DATA) ? 4'(tx_idx + spcs_pkg::IDX_ONE) : spcs_pkg::IDX_ZERO;
		end
	end

	// ****************************************
	// receiver
	// ****************************************
	// receiver checks one stop bit whatever the stop-count setting
	wire [3:0] rx_limit = (rx_state == spcs_pkg::SPCS_RX_START) ? spcs_pkg::OVS_HALF : spcs_pkg::OVS_LAST;
	wire rx_sample = rx_tick && (sync_mode || rx_sub == rx_limit);                  // see R24
	wire rx_done   = rx_sample && rx_state == spcs_pkg::SPCS_RX_STOP;
	wire fe_event  = rx_done && !rx_line;
	wire rx_par_val = spcs_parity(receive_shifter[7:0], seven, par_sel);            // see R2

	always_comb begin
		next_rx_state = rx_state;
		unique case (rx_state)
			spcs_pkg::SPCS_RX_IDLE: begin
				if (rx_tick && !rx_line)
					next_rx_state = sync_mode ? spcs_pkg::SPCS_RX_DATA : spcs_pkg::SPCS_RX_START;
			end
			spcs_pkg::SPCS_RX_START: begin
				if (rx_sample)
					next_rx_state = rx_line ? spcs_pkg::SPCS_RX_IDLE : spcs_pkg::SPCS_RX_DATA;
			end
			spcs_pkg::SPCS_RX_DATA: begin
				if (rx_sample && rx_idx == last_idx)
					next_rx_state = par_on ? spcs_pkg::SPCS_RX_PAR : spcs_pkg::SPCS_RX_STOP; // see R1
			end
			spcs_pkg::SPCS_RX_PAR: begin
				if (rx_sample)
					next_rx_state = spcs_pkg::SPCS_RX_STOP;
			end
			spcs_pkg::SPCS_RX_STOP: begin
				if (rx_sample)
					next_rx_state = spcs_pkg::SPCS_RX_IDLE;
			end
			default: next_rx_state = spcs_pkg::SPCS_RX_IDLE;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			rx_state        <= spcs_pkg::SPCS_RX_IDLE;
			receive_shifter <= 9'h000;
			rx_sub          <= spcs_pkg::IDX_ZERO;
			rx_idx          <= spcs_pkg::IDX_ZERO;
			rx_par_bad      <= 1'b0;
		end else begin
			rx_state <= next_rx_state;
			if (rx_state == spcs_pkg::SPCS_RX_IDLE) begin
				receive_shifter <= 9'h000;
				rx_idx          <= spcs_pkg::IDX_ZERO;
				rx_par_bad      <= 1'b0;
			end else if (rx_sample && rx_state == spcs_pkg::SPCS_RX_DATA) begin
				receive_shifter[rx_idx] <= rx_line;
				rx_idx <= 4'(rx_idx + spcs_pkg::IDX_ONE);
			end else if (rx_sample && rx_state == spcs_pkg::SPCS_RX_PAR) begin
				rx_par_bad <= rx_line != rx_par_val;                                    // see R1
			end
			if (rx_sample || rx_state == spcs_pkg::SPCS_RX_IDLE)
				rx_sub <= spcs_pkg::IDX_ZERO;
			else if (rx_tick)
				rx_sub <= 4'(rx_sub + spcs_pkg::IDX_ONE);
		end
	end

	// ****************************************
	// buffers and status flags
	// ****************************************
	// on overrun the unread character is kept and the new one dropped
	wire rx_store = rx_done && !rx_full_flag;
	wire attention_enable_hit = rx_done && nine && receive_shifter[8];

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			receive_buffer    <= spcs_pkg::REG_RESET;
			rx_ninth_bit      <= 1'b0;
			tx_empty_flag     <= 1'b1;
			rx_full_flag      <= 1'b0;
			overrun_error     <= 1'b0;
			framing_error     <= 1'b0;
			parity_error      <= 1'b0;
			rx_line_indicator <= 1'b0;
		end else begin
			if (rx_store) begin
				receive_buffer <= receive_shifter[7:0];
				rx_ninth_bit   <= nine && receive_shifter[8];                           // see R11
			end
			tx_empty_flag     <= tx_load || (tx_empty_flag && !wr_txbuf);              // see R8
			rx_full_flag      <= rx_done || (rx_full_flag && !rd_rxbuf);               // see R7
			overrun_error     <= (rx_done && rx_full_flag) || (overrun_error && !rd_rxst); // see R27
			framing_error     <= fe_event || (framing_error && !rd_rxst);              // see R10
			parity_error      <= (rx_done && par_on && rx_par_bad) || (parity_error && !rd_rxst); // see R10
			rx_line_indicator <= fe_event || (rx_line_indicator && !rx_line);          // see R14
		end
	end

	// ****************************************
	// register port
	// ****************************************
	wire [7:0] ctrl_rd = (ctrl_cfg & spcs_pkg::CTRL_WMASK) | ({7'h00, err_any} << spcs_pkg::C_ERR)
		| ({7'h00, rx_full_flag} << spcs_pkg::C_RX_FULL_FLAG) | ({7'h00, tx_empty_flag} << spcs_pkg::C_TX_EMPTY_FLAG);
	wire [7:0] rxst_rd = (rxst_cfg & spcs_pkg::RXST_WMASK) | ({7'h00, overrun_error} << spcs_pkg::S_DOE)
		| ({7'h00, framing_error} << spcs_pkg::S_FE) | ({7'h00, parity_error} << spcs_pkg::S_PE)
		| ({7'h00, rx_ninth_bit} << spcs_pkg::S_RX_NINTH_BIT) | ({7'h00, tx_active} << spcs_pkg::S_TX_ACTIVE)
		| ({7'h00, rx_line_indicator} << spcs_pkg::S_RX_LINE_INDICATOR);
	logic [7:0] next_rdata;

	always_comb begin
		unique case (addr)
			spcs_pkg::ADDR_TX_BUF:  next_rdata = transmit_buffer;
			spcs_pkg::ADDR_RX_BUF:  next_rdata = receive_buffer;
			spcs_pkg::ADDR_DIVISOR: next_rdata = divisor;
			spcs_pkg::ADDR_CTRL:    next_rdata = ctrl_rd;
			spcs_pkg::ADDR_RXST:    next_rdata = rxst_rd;
			spcs_pkg::ADDR_ICS:     next_rdata = ics;
			default:                next_rdata = spcs_pkg::REG_RESET;
		endcase
	end

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			ctrl_cfg        <= spcs_pkg::REG_RESET;
			rxst_cfg        <= spcs_pkg::REG_RESET;
			ics             <= spcs_pkg::REG_RESET;
			divisor         <= spcs_pkg::DIVISOR_RESET;
			transmit_buffer <= spcs_pkg::REG_RESET;
			rdata           <= spcs_pkg::REG_RESET;
		end else begin
			rdata <= rd_en ? next_rdata : spcs_pkg::REG_RESET;
			if (wr_en && addr == spcs_pkg::ADDR_CTRL)
				ctrl_cfg <= wdata & spcs_pkg::CTRL_WMASK;                                 // see R4
			if (wr_en && addr == spcs_pkg::ADDR_ICS)
				ics <= wdata;                                                             // see R23
			if (wr_en && addr == spcs_pkg::ADDR_DIVISOR)
				divisor <= wdata;
			if (wr_txbuf)
				transmit_buffer <= wdata;
			// the hardware clear of attention wins over a same-cycle write
			if (wr_en && addr == spcs_pkg::ADDR_RXST)
				rxst_cfg <= (wdata & spcs_pkg::RXST_WMASK) & ~({7'h00, attention_enable_hit} << spcs_pkg::S_ATTENTION_ENABLE); // see R9
			else if (attention_enable_hit)
				rxst_cfg[spcs_pkg::S_ATTENTION_ENABLE] <= 1'b0;                                       // see R12
		end
	end

	// ****************************************
	// pins and interrupt requests
	// ****************************************
	assign tx_pin_enable  = ics[spcs_pkg::I_TX_PIN_ENABLE];                                     // see R17
	assign tx_pin_oe_n    = ~ics[spcs_pkg::I_TX_PIN_ENABLE];                                    // see R17
	assign tx_irq_pending = tx_empty_flag && ics[spcs_pkg::I_ETI];                     // see R25
	assign rx_irq_pending = rx_full_flag && ics[spcs_pkg::I_ERI];                      // see R26, R22

	// ****************************************
	// assertions
	// ****************************************
	default clocking spcs_cb @(posedge clk); endclocking
	default disable iff (!rst_n);

	a_tx_load_empty: assert property (tx_load |=> tx_empty_flag && tx_state == spcs_pkg::SPCS_TX_START) // see R8
		else $error("transmit load did not set empty flag");
	a_tx_write_clear: assert property (wr_txbuf |=> !tx_empty_flag) // see R8
		else $error("buffer write did not clear empty flag");
	a_rx_read_clear: assert property (rd_rxbuf && !rx_done |=> !rx_full_flag) // see R7
		else $error("buffer read did not clear full flag");
	a_overrun_set: assert property (rx_done && rx_full_flag |=> overrun_error && err_any) // see R27
		else $error("overrun not flagged");
	a_errors_read_clear: assert property (rd_rxst && !rx_done |=> !overrun_error && !framing_error && !parity_error) // see R10
		else $error("status read did not clear errors");
	a_attention_enable_auto_clear: assert property (attention_enable_hit |=> !attention_enable) // see R12
		else $error("attention bit not cleared");
	a_parity_state_gate: assert property (tx_state == spcs_pkg::SPCS_TX_PAR |-> !nine && ctrl_cfg[spcs_pkg::C_PEN]) // see R1
		else $error("parity sent outside parity frames");
	a_tx_active_held: assert property (tx_load |=> tx_active [*2]) // see R13
		else $error("transmitting indicator dropped");
	a_fe_indicator: assert property (fe_event |=> rx_line_indicator && framing_error) // see R14
		else $error("framing error not indicated");
	a_idle_line_high: assert property (tx_state == spcs_pkg::SPCS_TX_IDLE && !tx_load |=> serial_tx_pin) // see R13
		else $error("line not idle high");

	c_tx_frame_done: cover property (tx_done);
	c_rx_frame_done: cover property (rx_done && !rx_full_flag);
	c_rx_overrun:    cover property (rx_done && rx_full_flag);
	c_rx_framing:    cover property (fe_event);

endmodule : spcs_serial_port

// ### spcs_pkg.sv
// serial port control/status: addresses, fields, encodings and states
// assumes a byte-wide register port with one-cycle read latency
package spcs_pkg;

	// ****************************************
	// register addresses
	// ****************************************
	localparam logic [7:0] ADDR_TX_BUF  = 8'hB6;
	localparam logic [7:0] ADDR_RX_BUF  = 8'hB7;
	localparam logic [7:0] ADDR_DIVISOR = 8'hB9;
	localparam logic [7:0] ADDR_CTRL    = 8'hBA;
	localparam logic [7:0] ADDR_RXST    = 8'hBB;
	localparam logic [7:0] ADDR_ICS     = 8'hBC;

	// ****************************************
	// write masks and reset values
	// ****************************************
	localparam logic [7:0] CTRL_WMASK    = 8'hF8;
	localparam logic [7:0] RXST_WMASK    = 8'h14;
	localparam logic [7:0] REG_RESET     = 8'h00;
	localparam logic [7:0] DIVISOR_RESET = 8'h00;

	// ****************************************
	// field positions
	// ****************************************
	localparam int C_PEN   = 7;
	localparam int C_PARITY_SELECT_HI = 6;
	localparam int C_PARITY_SELECT_LO = 5;
	localparam int C_FRAME_LEN_HI  = 4;
	localparam int C_FRAME_LEN_LO  = 3;
	localparam int C_ERR   = 2;
	localparam int C_RX_FULL_FLAG  = 1;
	localparam int C_TX_EMPTY_FLAG  = 0;
	localparam int S_DOE   = 7;
	localparam int S_FE    = 6;
	localparam int S_PE    = 5;
	localparam int S_RSV   = 4;
	localparam int S_RX_NINTH_BIT = 3;
	localparam int S_ATTENTION_ENABLE  = 2;
	localparam int S_TX_ACTIVE  = 1;
	localparam int S_RX_LINE_INDICATOR  = 0;
	localparam int I_TWO_STOP_SELECT  = 7;
	localparam int I_SHORT_STOP_SELECT = 6;
	localparam int I_TX_PIN_ENABLE  = 5;
	localparam int I_SSEL  = 4;
	localparam int I_RX_EXT_CLOCK_SELECT = 3;
	localparam int I_TX_EXT_CLOCK_SELECT = 2;
	localparam int I_ERI   = 1;
	localparam int I_ETI   = 0;

	// ****************************************
	// encodings and timing
	// ****************************************
	localparam logic [1:0] FLEN_8    = 2'h0;
	localparam logic [1:0] FLEN_7    = 2'h1;
	localparam logic [1:0] FLEN_9    = 2'h2;
	localparam logic [1:0] FLEN_LOOP = 2'h3;
	localparam logic [1:0] PAR_ODD   = 2'h0;
	localparam logic [1:0] PAR_EVEN  = 2'h1;
	localparam logic [1:0] PAR_MARK  = 2'h2;
	localparam logic [1:0] PAR_SPACE = 2'h3;
	localparam logic [3:0] OVS_LAST  = 4'hF;
	localparam logic [3:0] OVS_HALF  = 4'h7;
	localparam logic [3:0] OVS_SHORT = 4'hD;
	localparam logic [3:0] IDX_7     = 4'h6;
	localparam logic [3:0] IDX_8     = 4'h7;
	localparam logic [3:0] IDX_9     = 4'h8;
	localparam logic [3:0] IDX_ZERO  = 4'h0;
	localparam logic [3:0] IDX_ONE   = 4'h1;
	localparam logic [7:0] CNT_ONE   = 8'h01;

	typedef enum logic [2:0] {
		SPCS_TX_IDLE  = 3'b000,
		SPCS_TX_START = 3'b001,
		SPCS_TX_DATA  = 3'b010,
		SPCS_TX_PAR   = 3'b011,
		SPCS_TX_STOP1 = 3'b100,
		SPCS_TX_STOP2 = 3'b101
	} spcs_tx_t;

	typedef enum logic [2:0] {
		SPCS_RX_IDLE  = 3'b000,
		SPCS_RX_START = 3'b001,
		SPCS_RX_DATA  = 3'b010,
		SPCS_RX_PAR   = 3'b011,
		SPCS_RX_STOP  = 3'b100
	} spcs_rx_t;

endpackage : spcs_pkg

// ### spcs_remote_peer.sv
// remote serial device: sends async 8-bit frames and captures the device's frames
// assumes divisor 0, so one bit lasts 16 clocks
`timescale 1ns/10ps
module spcs_remote_peer (
	// clock
	input  wire logic clk,
	// serial lines
	input  wire logic line_from_dut,
	output logic      line_to_dut
);
	// ****************************************
	// frame driver and capture
	// ****************************************
	initial line_to_dut = 1'b1;
	// a bad stop is cut short so the low line cannot start a false frame
	task automatic send(input logic [7:0] d, input logic stop);
		logic [9:0] f;
		f = {stop, d, 1'b0};
		for (int i = 0; i < 10; i++) begin
			line_to_dut <= f[i];
			repeat ((i == 9 && !stop) ? 12 : 16) @(posedge clk);
		end
		line_to_dut <= 1'b1;
	endtask : send
	task automatic grab(output logic [7:0] d, output logic ok);
		ok = 1'b0;
		d  = 8'h00;
		// sampled between edges so the line has settled
		for (int n = 0; n < 2000 && line_from_dut !== 1'b0; n++) @(negedge clk);
		if (line_from_dut === 1'b0) begin
			repeat (8) @(negedge clk);
			for (int i = 0; i < 8; i++) begin
				repeat (16) @(negedge clk);
				d[i] = line_from_dut; // lsb first
			end
			// ninth slot: stop bit, or parity when enabled
			repeat (16) @(negedge clk);
			ok = line_from_dut;
		end
	endtask : grab
endmodule : spcs_remote_peer

// ### tb_spcs_serial_port.sv
// testbench: register port, reset values, transmit, receive, errors
// assumes divisor 0 and async 8-bit frames on the line
`timescale 1ns/10ps
module tb_spcs_serial_port;
	logic       clk = 1'b0, rst_n = 1'b0, wr_en = 1'b0, rd_en = 1'b0, ok;
	logic [7:0] addr = 8'h00, wdata = 8'h00, rdata, got, r, lfsr = 8'h2C;
	logic       rx_line, tx_line, tx_en, tx_oe_n, tx_irq, rx_irq;
	int         miscompares = 0, total_checks = 0;
	logic [7:0] q_sent[$];
	always #20 clk = ~clk;
	spcs_serial_port i_spcs_serial_port (.clk(clk), .rst_n(rst_n), .addr(addr), .wdata(wdata), .wr_en(wr_en),
		.rd_en(rd_en), .rdata(rdata), .serial_rx_pin(rx_line), .serial_ext_clock_pin(1'b1),
		.serial_tx_pin(tx_line), .tx_pin_enable(tx_en), .tx_pin_oe_n(tx_oe_n), .tx_irq_pending(tx_irq),
		.rx_irq_pending(rx_irq));
	spcs_remote_peer i_spcs_remote_peer (.clk(clk), .line_from_dut(tx_line), .line_to_dut(rx_line));
	// ****************************************
	// helpers
	// ****************************************
	function automatic logic [7:0] rnd();
		lfsr = {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
		return lfsr;
	endfunction : rnd
	task automatic check(input logic [7:0] e, input logic [7:0] a);
		total_checks++;
		if (a !== e) begin
			miscompares++;
			$display("mismatch at %0t: expected %h got %h", $time, e, a);
		end
	endtask : check
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr_en <= 1'b1;
		@(posedge clk);
		wr_en <= 1'b0;
	endtask : wr
	task automatic rchk(input logic [7:0] a, input logic [7:0] e, input logic [7:0] m);
		@(posedge clk);
		addr  <= a;
		rd_en <= 1'b1;
		@(posedge clk);
		rd_en <= 1'b0;
		#1 check(e & m, rdata & m);
	endtask : rchk
	task automatic print_verdict();
		$display("checks %0d miscompares %0d", total_checks, miscompares);
		if (miscompares == 0 && total_checks > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : print_verdict
	task automatic wait_rx();
		int n;
		for (n = 0; n < 400 && rx_irq !== 1'b1; n++) @(negedge clk);
		if (n == 400) begin
			miscompares++;
			print_verdict();
		end
	endtask : wait_rx
	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (4) @(posedge clk);
		rst_n <= 1'b1;
		rchk(spcs_pkg::ADDR_CTRL, 8'h01, 8'hFF);
		rchk(spcs_pkg::ADDR_RXST, 8'h00, 8'hFF);
		rchk(spcs_pkg::ADDR_ICS, 8'h00, 8'hFF);
		rchk(8'h55, 8'h00, 8'hFF);
		check(8'h01, {7'h00, tx_oe_n});
		$display("test reset done");
		repeat (6) begin
			r = rnd();
			wr(spcs_pkg::ADDR_CTRL, r);
			rchk(spcs_pkg::ADDR_CTRL, (r & 8'hF8) | 8'h01, 8'hFF);
			wr(spcs_pkg::ADDR_RXST, r & 8'hEF);
			rchk(spcs_pkg::ADDR_RXST, r & 8'h04, 8'hFF);
			wr(spcs_pkg::ADDR_ICS, r);
			rchk(spcs_pkg::ADDR_ICS, r, 8'hFF);
			check({5'h00, r[5], ~r[5], r[0]}, {5'h00, tx_en, tx_oe_n, tx_irq});
		end
		wr(spcs_pkg::ADDR_CTRL, 8'h00);
		wr(spcs_pkg::ADDR_RXST, 8'h00);
		$display("test registers done");
		wr(spcs_pkg::ADDR_ICS, 8'h21);
		repeat (3) begin
			q_sent.push_back(rnd());
			fork
				i_spcs_remote_peer.grab(got, ok);
				wr(spcs_pkg::ADDR_TX_BUF, q_sent[$]);
			join
			check(q_sent.pop_front(), got);
			check(8'h01, {7'h00, ok});
		end
		r = rnd();
		wr(spcs_pkg::ADDR_CTRL, 8'hA0);
		fork
			i_spcs_remote_peer.grab(got, ok);
			wr(spcs_pkg::ADDR_TX_BUF, r);
		join
		check(r, got);
		check({7'h00, ^r}, {7'h00, ok});
		repeat (40) @(posedge clk);
		rchk(spcs_pkg::ADDR_RXST, 8'h00, 8'h02);
		wr(spcs_pkg::ADDR_CTRL, 8'h00);
		$display("test transmit done");
		wr(spcs_pkg::ADDR_ICS, 8'h02);
		repeat (2) begin
			q_sent.push_back(rnd());
			i_spcs_remote_peer.send(q_sent[$], 1'b1);
			wait_rx();
			rchk(spcs_pkg::ADDR_CTRL, 8'h03, 8'hFF);
			rchk(spcs_pkg::ADDR_RX_BUF, q_sent.pop_front(), 8'hFF);
			check(8'h00, {7'h00, rx_irq});
		end
		$display("test receive done");
		i_spcs_remote_peer.send(8'hA5, 1'b0);
		wait_rx();
		rchk(spcs_pkg::ADDR_RXST, 8'h40, 8'hE0);
		repeat (8) @(posedge clk);
		rchk(spcs_pkg::ADDR_RXST, 8'h00, 8'hFF);
		i_spcs_remote_peer.send(8'h3C, 1'b1);
		repeat (8) @(posedge clk);
		rchk(spcs_pkg::ADDR_CTRL, 8'h07, 8'hFF);
		rchk(spcs_pkg::ADDR_RXST, 8'h80, 8'hFF);
		rchk(spcs_pkg::ADDR_RX_BUF, 8'hA5, 8'hFF);
		rchk(spcs_pkg::ADDR_CTRL, 8'h01, 8'hFF);
		$display("test errors done");
		r = rnd();
		wr(spcs_pkg::ADDR_CTRL, 8'h38);
		wr(spcs_pkg::ADDR_RXST, 8'h04);
		wr(spcs_pkg::ADDR_TX_BUF, r);
		wait_rx();
		rchk(spcs_pkg::ADDR_RXST, 8'h08, 8'hFD);
		rchk(spcs_pkg::ADDR_RX_BUF, r, 8'hFF);
		$display("test loopback done");
		print_verdict();
	end
endmodule : tb_spcs_serial_port
